// >>> sar_adc_conversion_control.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "sar_conv_defs.svh"

// Operation
// - Without external enable, only software start bit starts
// - With external enable, start bit or pin edge
// - Pin edge seen at cycle end, start next
// - Software start begins at next machine cycle
// - Start command and busy status are separate flops
// - Two initiation cycles, busy set after first
// - Eight machine cycles sampling the selected channel
// - Load top bit, keep if input above ladder
// - Four cycles per bit down to bit zero
// - Done flag, result high byte, two low bits
// - Done set, busy cleared after 52 cycles
// - Control bits one and zero select channel
// - Start requests ignored while converting
// - Idle or power-down aborts running conversion
// - Result frozen while done flag is set
// - Code spans all zeros to all ones
module sar_adc_conversion_control #(
  parameter int MC_CLKS = 4
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  input  wire logic                  CE,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  EXTERNAL_START_PIN,
  input  wire logic                  COMPARATOR_IN,
  input  wire logic                  IDLE_MODE,
  input  wire logic                  POWER_DOWN,
  output sar_conv_pkg::ana_ctl_t     ANA_CTL,
  output logic                       IRQ
);
  import sar_conv_pkg::*;

  conv_state_t state_ff;
  logic [7:0]  mc_clk_cnt_ff;
  logic [5:0]  mc_idx_ff;
  logic        tick;
  logic        low_power;
  logic        ext_meta_ff;
  logic        ext_sync_ff;
  logic        ext_prev_ff;
  logic        comp_meta_ff;
  logic        comp_sync_ff;
  logic        ext_edge;
  logic        start_now;
  logic        finish_now;
  logic        abort_now;
  logic        start_cmd_ff;
  logic        start_busy_ff;
  logic        external_start_enable_ff;
  logic        conversion_done_flag_ff;
  logic [1:0]  chan_sel_ff;
  logic [1:0]  chan_run_ff;
  logic [9:0]  sar_ff;
  logic [7:0]  res_high_ff;
  logic [1:0]  res_low_ff;
  logic [`INT_BITS-1:0] int_status_ff;
  logic [`INT_BITS-1:0] int_mask_ff;
  logic [`INT_BITS-1:0] int_events;
  logic [`INT_BITS-1:0] int_clear;
  logic        irq_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        apb_setup;
  logic        apb_write;
  logic        wr_control;
  logic [3:0]  trial_pos;
  logic [1:0]  trial_phase;

  // Bit under trial for a given machine-cycle index within the approximation phase.
  function automatic logic [3:0] trial_bit(input logic [5:0] idx);
    logic [5:0] rel;
    rel = 6'(idx - `MC_CONV_FIRST);
    trial_bit = 4'(`SAR_MSB - rel[5:2]);
  endfunction

  function automatic logic [1:0] trial_step(input logic [5:0] idx);
    logic [5:0] rel;
    rel = 6'(idx - `MC_CONV_FIRST);
    trial_step = rel[1:0];
  endfunction

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == `OFF_CONTROL) || (addr == `OFF_RESULT_HIGH) ||
                  (addr == `OFF_INT_STATUS) || (addr == `OFF_INT_MASK);
  endfunction

  assign low_power   = IDLE_MODE | POWER_DOWN;
  assign tick        = CE && (mc_clk_cnt_ff == 8'(MC_CLKS - 1));
  assign trial_pos   = trial_bit(mc_idx_ff);
  assign trial_phase = trial_step(mc_idx_ff);

  // The pin is looked at only once per machine cycle, so a pulse shorter than one cycle may be missed.
  assign ext_edge   = external_start_enable_ff && ext_sync_ff && !ext_prev_ff;
  assign start_now  = tick && (state_ff == ST_IDLE) && !low_power && (start_cmd_ff || ext_edge);
  assign finish_now = tick && (state_ff == ST_FINISH) && (mc_idx_ff == `MC_TOTAL_END);
  assign abort_now  = CE && low_power && (state_ff != ST_IDLE);

  assign apb_setup  = CE && PSEL && !PENABLE;
  assign apb_write  = CE && PSEL && PENABLE && PWRITE;
  assign wr_control = apb_write && (PADDR == `OFF_CONTROL);

  // Machine-cycle divider.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mc_clk_cnt_ff <= 8'h00;
    end else if (CE) begin
      if (tick) begin
        mc_clk_cnt_ff <= 8'h00;
      end else begin
        mc_clk_cnt_ff <= 8'(mc_clk_cnt_ff + 8'h01);
      end
    end
  end

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ext_meta_ff  <= 1'b0;
      ext_sync_ff  <= 1'b0;
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else if (CE) begin
      ext_meta_ff  <= EXTERNAL_START_PIN;
      ext_sync_ff  <= ext_meta_ff;
      comp_meta_ff <= COMPARATOR_IN;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  // Pin level at the end of each machine cycle, for edge recognition.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      ext_prev_ff <= 1'b1;
    end else if (tick) begin
      ext_prev_ff <= ext_sync_ff;
    end
  end

  // Sequencer.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_ff  <= ST_IDLE;
      mc_idx_ff <= `MC_ZERO;
    end else if (abort_now) begin
      state_ff  <= ST_IDLE;
      mc_idx_ff <= `MC_ZERO;
    end else if (tick) begin
      case (state_ff)
        ST_IDLE: begin
          if (start_now) begin
            state_ff  <= ST_INIT;
            mc_idx_ff <= `MC_ZERO;
          end
        end
        ST_INIT: begin
          mc_idx_ff <= 6'(mc_idx_ff + `MC_ONE);
          if (mc_idx_ff == `MC_INIT_END) begin
            state_ff <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          mc_idx_ff <= 6'(mc_idx_ff + `MC_ONE);
          if (mc_idx_ff == `MC_SAMPLE_END) begin
            state_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          mc_idx_ff <= 6'(mc_idx_ff + `MC_ONE);
          if (mc_idx_ff == `MC_CONV_END) begin
            state_ff <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          mc_idx_ff <= 6'(mc_idx_ff + `MC_ONE);
          if (mc_idx_ff == `MC_TOTAL_END) begin
            state_ff  <= ST_IDLE;
            mc_idx_ff <= `MC_ZERO;
          end
        end
        default: begin
          state_ff  <= ST_IDLE;
          mc_idx_ff <= `MC_ZERO;
        end
      endcase
    end
  end

  // Start command flop: set by software, consumed when the sequence begins.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      start_cmd_ff <= 1'b0;
    end else if (CE) begin
      if (low_power || start_now) begin
        start_cmd_ff <= 1'b0;
      end else if (wr_control && PWDATA[`CTL_START] && (state_ff == ST_IDLE)) begin
        start_cmd_ff <= 1'b1;
      end
    end
  end

  // Busy status flop, which is what software reads back in the start position.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      start_busy_ff <= 1'b0;
    end else if (abort_now || finish_now) begin
      start_busy_ff <= 1'b0;
    end else if (tick && (state_ff == ST_INIT) && (mc_idx_ff == `MC_BUSY_SET)) begin
      start_busy_ff <= 1'b1;
    end
  end

  // Channel chosen by software, and the copy frozen for the running conversion.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      chan_sel_ff <= `RST_CHAN;
      chan_run_ff <= `RST_CHAN;
    end else if (CE) begin
      if (wr_control) begin
        chan_sel_ff <= PWDATA[`CTL_CHAN_HI:`CTL_CHAN_LO];
      end
      if (start_now) begin
        chan_run_ff <= chan_sel_ff;
      end
    end
  end

  // Successive approximation register. Comparator high means the input is above the ladder voltage.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sar_ff <= `RST_SAR;
    end else if (tick) begin
      if ((state_ff == ST_SAMPLE) && (mc_idx_ff == `MC_SAMPLE_END)) begin
        sar_ff <= `SAR_TOP;
      end else if ((state_ff == ST_CONV) && (trial_phase == `PHASE_LAST)) begin
        if (!comp_sync_ff) begin
          sar_ff[trial_pos] <= 1'b0;
        end
        if (trial_pos != `SAR_LSB) begin
          sar_ff[4'(trial_pos - 4'd1)] <= 1'b1;
        end
      end
    end
  end

  // Result store; a pending result is never overwritten while the done flag is still up.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      res_high_ff <= `RST_RESULT_HIGH;
      res_low_ff  <= `RST_RESULT_LOW;
    end else if (finish_now && !conversion_done_flag_ff) begin
      res_high_ff <= sar_ff[9:2];
      res_low_ff  <= sar_ff[1:0];
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      conversion_done_flag_ff <= 1'b0;
    end else if (finish_now) begin
      conversion_done_flag_ff <= 1'b1;
    end else if (wr_control && !PWDATA[`CTL_DONE]) begin
      conversion_done_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      external_start_enable_ff <= 1'b0;
    end else if (wr_control) begin
      external_start_enable_ff <= PWDATA[`CTL_EXT_EN];
    end
  end

  // Interrupt status, mask and output.
  assign int_events = {abort_now, finish_now};
  assign int_clear  = (apb_write && (PADDR == `OFF_INT_STATUS)) ? PWDATA[`INT_BITS-1:0] : `RST_INT;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      int_status_ff <= `RST_INT;
      int_mask_ff   <= `RST_INT;
      irq_ff        <= 1'b0;
    end else if (CE) begin
      int_status_ff <= (int_status_ff & ~int_clear) | int_events;
      if (apb_write && (PADDR == `OFF_INT_MASK)) begin
        int_mask_ff <= PWDATA[`INT_BITS-1:0];
      end
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  // Read data is captured in the setup cycle so the access phase completes at once.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prdata_ff  <= `RST_WORD;
      pslverr_ff <= 1'b0;
    end else if (apb_setup) begin
      pslverr_ff <= !addr_mapped(PADDR);
      case (PADDR)
        `OFF_CONTROL: begin
          prdata_ff <= {24'h000000, res_low_ff, external_start_enable_ff, conversion_done_flag_ff,
                        start_busy_ff, 1'b0, chan_sel_ff};
        end
        `OFF_RESULT_HIGH: begin
          prdata_ff <= {24'h000000, res_high_ff};
        end
        `OFF_INT_STATUS: begin
          prdata_ff <= {30'h0, int_status_ff};
        end
        `OFF_INT_MASK: begin
          prdata_ff <= {30'h0, int_mask_ff};
        end
        default: begin
          prdata_ff <= `RST_WORD;
        end
      endcase
    end
  end

  assign PRDATA  = prdata_ff;
  assign PSLVERR = pslverr_ff;
  assign PREADY  = CE;
  assign IRQ     = irq_ff;

  assign ANA_CTL = {(state_ff == ST_SAMPLE),
                    chan_run_ff,
                    sar_ff};

  // Helper: machine cycles elapsed since the start was taken.
  logic [7:0] mc_since_start_ff;
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mc_since_start_ff <= 8'h00;
    end else if (start_now) begin
      mc_since_start_ff <= 8'h00;
    end else if (tick && (state_ff != ST_IDLE)) begin
      mc_since_start_ff <= 8'(mc_since_start_ff + 8'h01);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sw_only_start_a: assert property (
    (state_ff == ST_IDLE) && !external_start_enable_ff && !start_cmd_ff |=> (state_ff == ST_IDLE))
    else $error("conversion began without a software start");

  pin_edge_start_a: assert property (
    start_now && !start_cmd_ff && !abort_now |=> (state_ff == ST_INIT) && ext_prev_ff)
    else $error("pin start not taken on the next machine cycle");

  busy_after_first_a: assert property (
    tick && (state_ff == ST_INIT) && (mc_idx_ff == `MC_BUSY_SET) && !low_power |=> start_busy_ff)
    else $error("busy not set after the first initiation cycle");

  sar_top_load_a: assert property (
    tick && (state_ff == ST_SAMPLE) && (mc_idx_ff == `MC_SAMPLE_END) && !low_power
    |=> (sar_ff == `SAR_TOP) && (state_ff == ST_CONV))
    else $error("approximation did not start with the top bit only");

  done_at_52_a: assert property (
    $rose(conversion_done_flag_ff) |-> (mc_since_start_ff == `CONV_MC_TOTAL) && !start_busy_ff)
    else $error("done flag not raised 52 machine cycles after start");

  result_copy_a: assert property (
    finish_now && !conversion_done_flag_ff |=> (res_high_ff == sar_ff[9:2]) && (res_low_ff == sar_ff[1:0]))
    else $error("result registers do not match the approximation");

  no_restart_busy_a: assert property (
    (state_ff != ST_IDLE) |-> !start_cmd_ff)
    else $error("start request accepted while converting");

  abort_on_sleep_a: assert property (
    abort_now |=> (state_ff == ST_IDLE) && !start_busy_ff && !start_cmd_ff)
    else $error("conversion not aborted on idle or power-down");

  result_hold_a: assert property (
    conversion_done_flag_ff |=> $stable(res_high_ff) && $stable(res_low_ff))
    else $error("result changed while done flag was set");

  channel_frozen_a: assert property (
    (state_ff != ST_IDLE) |=> $stable(ANA_CTL.mux_sel))
    else $error("channel changed during a running conversion");

  full_conv_c: cover property (start_now ##[1:300] finish_now);
  abort_c: cover property ((state_ff == ST_CONV) && abort_now);
  pin_start_c: cover property (start_now && !start_cmd_ff);
  full_scale_c: cover property (finish_now && (sar_ff == 10'h3ff));

endmodule

// >>> sar_conv_defs.svh
`ifndef SAR_CONV_DEFS_SVH
`define SAR_CONV_DEFS_SVH

// Register byte offsets on the APB slave.
`define OFF_CONTROL      8'h00
`define OFF_RESULT_HIGH  8'h04
`define OFF_INT_STATUS   8'h08
`define OFF_INT_MASK     8'h0c

// Field positions inside converter_control.
`define CTL_RES_LO_HI    7
`define CTL_RES_LO_LO    6
`define CTL_EXT_EN       5
`define CTL_DONE         4
`define CTL_START        3
`define CTL_CHAN_HI      1
`define CTL_CHAN_LO      0

// Sticky interrupt status and mask bits.
`define INT_DONE         0
`define INT_ABORT        1
`define INT_BITS         2

// Reset values.
`define RST_CHAN         2'h0
`define RST_SAR          10'h000
`define RST_RESULT_HIGH  8'h00
`define RST_RESULT_LOW   2'h0
`define RST_INT          2'h0
`define RST_WORD         32'h0000_0000

// Sequence points, counted in machine cycles from the first initiation cycle.
`define MC_BUSY_SET      6'd0
`define MC_INIT_END      6'd1
`define MC_SAMPLE_END    6'd9
`define MC_CONV_FIRST    6'd10
`define MC_CONV_END      6'd49
`define MC_TOTAL_END     6'd51
`define MC_ZERO          6'd0
`define MC_ONE           6'd1
`define CONV_MC_TOTAL    8'd52
`define PHASE_LAST       2'd3
`define SAR_TOP          10'h200
`define SAR_MSB          4'd9
`define SAR_LSB          4'd0

`endif

// >>> sar_conv_pkg.sv
package sar_conv_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_INIT   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b011,
    ST_FINISH = 3'b100
  } conv_state_t;

  // Drive towards the analog comparator, ladder DAC and input multiplexer.
  typedef struct packed {
    logic       sample_en;
    logic [1:0] mux_sel;
    logic [9:0] dac_code;
  } ana_ctl_t;

endpackage

// >>> sar_analog_model.sv
`timescale 1ns/1ps

module sar_analog_model (
  input  wire sar_conv_pkg::ana_ctl_t ANA_CTL,
  input  wire logic                   CLK,
  input  wire logic [3:0][9:0]        LEVEL,
  output logic                        COMPARATOR_IN
);
  import sar_conv_pkg::*;
  logic [9:0] held_ff;

  // The hold capacitor keeps the last sample, so input moves after sampling stay unseen.
  always_ff @(posedge CLK) begin
    if (ANA_CTL.sample_en) begin
      held_ff <= LEVEL[ANA_CTL.mux_sel];
    end
  end

  // A level sits half a step above its tap, so every tap at or below it reads as lower.
  assign COMPARATOR_IN = (held_ff >= ANA_CTL.dac_code);
endmodule

// >>> sar_adc_conversion_control_tb.sv
`timescale 1ns/1ps
`include "sar_conv_defs.svh"

module sar_adc_conversion_control_tb;
  import sar_conv_pkg::*;
  localparam int MC   = 4;
  localparam int CONV = 52 * MC;
  logic            clk;
  logic            rst_b;
  logic            ce;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic            pready;
  logic            pslverr;
  logic            serr;
  logic            ext_pin;
  logic            comp;
  logic            idle;
  logic            pdown;
  logic            irq;
  logic [7:0]      paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic [31:0]     rdata;
  ana_ctl_t        ana;
  logic [3:0][9:0] level;
  logic [15:0]     seed;
  logic [9:0]      res;
  logic [9:0]      want;
  logic [1:0]      ch;
  logic [1:0]      lo;
  int              err_count;
  int              check_count;
  int              cyc;
  int              t0;
  int              d;

  sar_adc_conversion_control #(.MC_CLKS(MC)) sar_adc_conversion_control_i (
    .CLK(clk), .RST_B(rst_b), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXTERNAL_START_PIN(ext_pin), .COMPARATOR_IN(comp), .IDLE_MODE(idle),
    .POWER_DOWN(pdown), .ANA_CTL(ana), .IRQ(irq));

  sar_analog_model sar_analog_model_i (.CLK(clk), .ANA_CTL(ana), .LEVEL(level), .COMPARATOR_IN(comp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction

  function automatic logic [31:0] ctl_word(input logic [1:0] rl, input logic ext, input logic done,
                                           input logic busy, input logic [1:0] c);
    return {24'h000000, rl, ext, done, busy, 1'b0, c};
  endfunction

  function automatic logic [31:0] in_range(input int v, input int lo_b, input int hi_b);
    return {31'h0, (v >= lo_b) && (v <= hi_b)};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog may end a wait for the slave's answer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rdata, exp);
  endtask

  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    n = 0;
    while (irq !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    d = cyc - t0;
  endtask

  task automatic convert(input logic [1:0] c, input logic keep_done);
    apb(1'b1, `OFF_CONTROL, ctl_word(2'h0, 1'b0, keep_done, 1'b1, c));
    #1;
    t0 = cyc;
  endtask

  task automatic get_res;
    apb(1'b0, `OFF_RESULT_HIGH, 32'h0);
    res[9:2] = rdata[7:0];
    apb(1'b0, `OFF_CONTROL, 32'h0);
    res[1:0] = rdata[7:6];
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    $display("Error watchdog expected finish seen timeout");
    close_out;
  end

  initial begin
    {rst_b, psel, penable, pwrite, ext_pin, idle, pdown} = 7'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    level = '0;
    seed = 16'd8886;
    lo = 2'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rdc("control", `OFF_CONTROL, 32'h0);
    rdc("result", `OFF_RESULT_HIGH, 32'h0);
    rdc("status", `OFF_INT_STATUS, 32'h0);
    rdc("mask", `OFF_INT_MASK, 32'h0);
    apb(1'b1, `OFF_RESULT_HIGH, 32'h0000_00ff);
    rdc("result read only", `OFF_RESULT_HIGH, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", {31'h0, serr}, 32'h1);
    apb(1'b1, `OFF_INT_MASK, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      for (int c = 0; c < 4; c++) begin
        seed = lfsr(seed);
        level[c] <= seed[9:0];
      end
      if (i == 0) level[0] <= 10'h000;
      if (i == 1) level[1] <= 10'h3ff;
      ch = i[1:0];
      convert(ch, 1'b0);
      repeat (60) @(posedge clk);
      // A second start and a channel change while converting must leave this one alone.
      apb(1'b1, `OFF_CONTROL, ctl_word(2'h0, 1'b0, 1'b0, 1'b1, ~ch));
      rdc("busy", `OFF_CONTROL, ctl_word(lo, 1'b0, 1'b0, 1'b1, ~ch));
      wait_irq(1'b1, CONV + 4 * MC);
      chk("latency", in_range(d, CONV + 1, CONV + MC + 2), 32'h1);
      get_res;
      chk("code", {22'h0, res}, {22'h0, level[ch]});
      lo = level[ch][1:0];
      rdc("done", `OFF_CONTROL, ctl_word(lo, 1'b0, 1'b1, 1'b0, ~ch));
      apb(1'b1, `OFF_INT_STATUS, 32'h1);
      wait_irq(1'b0, 4);
      chk("irq cleared", {31'h0, irq}, 32'h0);
    end
    $display("test conversions done");
    want = res;
    level <= ~level;
    convert(ch, 1'b1);
    repeat (CONV + 8 * MC) @(posedge clk);
    get_res;
    chk("held result", {22'h0, res}, {22'h0, want});
    idle <= 1'b1;
    repeat (5) @(posedge clk);
    idle <= 1'b0;
    get_res;
    chk("held in idle", {22'h0, res}, {22'h0, want});
    apb(1'b1, `OFF_CONTROL, ctl_word(2'h0, 1'b0, 1'b0, 1'b0, 2'h2));
    get_res;
    chk("kept after clear", {22'h0, res}, {22'h0, want});
    rdc("done cleared", `OFF_CONTROL, ctl_word(want[1:0], 1'b0, 1'b0, 1'b0, 2'h2));
    apb(1'b1, `OFF_INT_STATUS, 32'h3);
    $display("test hold done");
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, `OFF_CONTROL, ctl_word(2'h0, e[0], 1'b0, 1'b0, 2'h2));
      ext_pin <= 1'b0;
      repeat (3 * MC) @(posedge clk);
      ext_pin <= 1'b1;
      #1;
      t0 = cyc;
      wait_irq(1'b1, CONV + 8 * MC);
      chk("pin start", {31'h0, irq}, {31'h0, e[0]});
      if (e == 1) begin
        chk("pin latency", in_range(d, CONV + 1, CONV + 2 * MC + 4), 32'h1);
        get_res;
        chk("pin code", {22'h0, res}, {22'h0, level[2]});
        lo = level[2][1:0];
      end
      @(posedge clk);
      ext_pin <= 1'b0;
      apb(1'b1, `OFF_INT_STATUS, 32'h3);
    end
    $display("test pin start done");
    for (int a = 0; a < 2; a++) begin
      apb(1'b1, `OFF_CONTROL, ctl_word(2'h0, 1'b0, 1'b0, 1'b0, 2'h0));
      convert(2'h0, 1'b0);
      repeat (100) @(posedge clk);
      idle  <= (a == 0);
      pdown <= (a == 1);
      repeat (5) @(posedge clk);
      idle  <= 1'b0;
      pdown <= 1'b0;
      repeat (CONV) @(posedge clk);
      rdc("abort status", `OFF_INT_STATUS, 32'h2);
      rdc("abort control", `OFF_CONTROL, ctl_word(lo, 1'b0, 1'b0, 1'b0, 2'h0));
      chk("masked irq", {31'h0, irq}, 32'h0);
      apb(1'b1, `OFF_INT_MASK, 32'h3);
      repeat (2) @(posedge clk);
      chk("unmasked irq", {31'h0, irq}, 32'h1);
      apb(1'b1, `OFF_INT_STATUS, 32'h2);
      repeat (2) @(posedge clk);
      chk("w1c irq", {31'h0, irq}, 32'h0);
      apb(1'b1, `OFF_INT_MASK, 32'h1);
    end
    // Twenty clocks with the enable low must push the completion latency window back by twenty clocks.
    convert(2'h1, 1'b0);
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    wait_irq(1'b1, CONV + 8 * MC);
    chk("stalled latency", in_range(d, CONV + 21, CONV + MC + 22), 32'h1);
    get_res;
    chk("stalled code", {22'h0, res}, {22'h0, level[1]});
    $display("test abort done");
    close_out;
  end
endmodule
